// ===== hdl/conv_consts.svh
// Purpose: Shared constants of the conversion control block
// Assumes: 100 MHz sys_clk
// Notes:   Timing counts derived from printed times
`ifndef CONV_CONSTS_SVH
`define CONV_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS     10
`define CONV_TIME_NS      2000
`define CONV_CYCLES       (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define SPAN_SETTLE_US    80

// ****************************************
// Coding
// ****************************************
`define CHANNELS          4
`define CODE_W            16
`define CODE_STEPS        65536
`define FSR_WIDE_UV       20000000
`define FSR_NARROW_UV     10000000
`define CODE_MAX          48'h00000000FFFF
`define SIGN_FLIP         16'h8000
`define FIFO_DEPTH        16

`endif

// ===== hdl/conv_pkg.sv
// Purpose: Types of the conversion control block
// Assumes: conv_consts.svh included
// Notes:   Input voltages are signed microvolts
`include "conv_consts.svh"

package conv_pkg;

  typedef logic signed [31:0] volt_t;
  typedef logic [`CODE_W-1:0] code_t;
  typedef volt_t [`CHANNELS-1:0] volt_set_t;
  typedef code_t [`CHANNELS-1:0] code_set_t;

  typedef struct packed {
    logic [1:0] chan;
    code_t      code;
  } fifo_word_t;

  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_CONV  = 2'b01,
    ST_PUSH  = 2'b10
  } conv_state_t;

endpackage : conv_pkg

// ===== hdl/word_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Read data is the stored head word
`timescale 1ns/100ps
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,   // Clock
  input  wire logic             srst,      // Sync reset
  input  wire logic             in_valid,  // Write request
  output var  logic             in_ready,  // Not full
  input  wire logic [WIDTH-1:0] in_data,   // Write word
  output var  logic             out_valid, // Not empty
  input  wire logic             out_ready, // Read accept
  output var  logic [WIDTH-1:0] out_data   // Head word
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic        do_wr;
  logic        do_rd;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    do_wr   = in_valid && (st_reg.count != (AW+1)'(DEPTH));
    do_rd   = out_ready && (st_reg.count != '0);
    if (do_wr) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    case ({do_wr, do_rd})
      2'b10:   st_next.count = st_reg.count + 1'b1;
      2'b01:   st_next.count = st_reg.count - 1'b1;
      default: st_next.count = st_reg.count;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready  = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data  = st_reg.mem[st_reg.rd_ptr];

endmodule : word_fifo

`default_nettype wire

// ===== hdl/conv_control.sv
// Purpose: Sampling and conversion sequencing of a four-channel converter
// Assumes: Trigger and span pins asynchronous; inputs in signed microvolts
// Notes:   Results leave through the output register and a word FIFO
`timescale 1ns/100ps
`default_nettype none
`include "conv_consts.svh"

// Functional notes
// - Span select high gives a ten-volt bipolar span, low gives five volts, on all channels.
// - A trigger rising edge while not busy puts its own set's two track-and-holds into hold, capturing their inputs together.
// - Busy falls only after all four channel conversions are complete.
// - The conversion is timed internally and finishes within 2 us of its start.
// - At busy falling all track-and-holds return to track and acquisition begins.
// - New results are readable after busy falls; during busy the prior results are read.
// - Results are twos complement with transitions at one half and three halves LSB.
// - One LSB is the selected full-scale span divided by 65,536.
// - Busy rises on the third clock after the conversion-starting trigger edge (synchronizer), or the clock after ST_PUSH if later, and stays high to the end.
// - The first trigger holds channels one and two, the second three and four; both start.
module conv_control
  import conv_pkg::*;
(
  input  wire logic       sys_clk,                   // 100 MHz clock
  input  wire logic       srst,                      // Sync reset, high
  input  wire logic       sample_trigger_first_set,  // Trigger, channels 1-2
  input  wire logic       sample_trigger_second_set, // Trigger, channels 3-4
  input  wire logic       span_select,               // High wide span, low narrow
  input  wire volt_set_t  analog_in,                 // Channel inputs, microvolts
  output var  logic       busy,                      // Conversion in progress
  output var  logic [1:0] hold_state,                // Hold per set, bit0 set one
  output var  code_set_t  result,                    // Last completed results
  output var  logic       result_new,                // Results updated, pulse
  output var  logic       stream_valid,              // FIFO word present
  input  wire logic       stream_ready,              // FIFO word taken
  output var  fifo_word_t stream_data                // Channel and code
);

  typedef struct packed {
    logic [1:0]  sync_a;
    logic [1:0]  sync_b;
    logic [1:0]  sync_span;
    logic        prev_a;
    logic        prev_b;
    conv_state_t state;
    logic        busy;
    logic [1:0]  hold;
    logic [1:0]  span_held;
    volt_set_t   held;
    logic [7:0]  cnt;
    code_set_t   result;
    logic        result_new;
    logic [1:0]  push_idx;
    logic        out_valid;
    fifo_word_t  out_word;
  } ctl_state_t;

  localparam logic [7:0] CONV_LAST = 8'(`CONV_CYCLES - 1);

  ctl_state_t st_reg;
  ctl_state_t st_next;
  logic       edge_a;
  logic       edge_b;
  logic       push_valid;
  logic       push_ready;
  fifo_word_t push_word;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  fifo_word_t fifo_out_word;

  // ****************************************
  // Edge detect
  // ****************************************
  function automatic logic rise_of(input logic now_lvl, input logic was_lvl);
    return now_lvl && !was_lvl;
  endfunction : rise_of

  // ****************************************
  // Transfer function
  // ****************************************
  function automatic code_t code_of(input volt_t v, input logic wide);
    logic [47:0] fsr;
    logic [47:0] sh;
    logic [47:0] q;
    logic signed [47:0] half;
    logic signed [47:0] vv;
    fsr  = wide ? 48'(`FSR_WIDE_UV) : 48'(`FSR_NARROW_UV);
    half = $signed(fsr >> 1);
    vv   = 48'(v);
    if (vv < -half) begin
      vv = -half;
    end
    if (vv > half) begin
      vv = half;
    end
    sh = 48'(vv + half);
    // LSB = FSR/65536, rounding puts transitions at half LSB
    q  = (sh * 48'(2 * `CODE_STEPS) + fsr) / (fsr << 1);
    if (q > `CODE_MAX) begin
      q = `CODE_MAX;
    end
    return q[`CODE_W-1:0] ^ `SIGN_FLIP;
  endfunction : code_of

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.sync_a    = {st_reg.sync_a[0], sample_trigger_first_set};
    st_next.sync_b    = {st_reg.sync_b[0], sample_trigger_second_set};
    st_next.sync_span = {st_reg.sync_span[0], span_select};
    st_next.prev_a    = st_reg.sync_a[1];
    st_next.prev_b    = st_reg.sync_b[1];
    st_next.result_new = 1'b0;
    edge_a = rise_of(st_reg.sync_a[1], st_reg.prev_a);
    edge_b = rise_of(st_reg.sync_b[1], st_reg.prev_b);

    // Capture per set while not converting
    if (st_reg.state != ST_CONV) begin
      if (edge_a && !st_reg.hold[0]) begin
        st_next.hold[0]      = 1'b1;
        st_next.held[0]      = analog_in[0];
        st_next.held[1]      = analog_in[1];
        st_next.span_held[0] = st_reg.sync_span[1];
      end
      if (edge_b && !st_reg.hold[1]) begin
        st_next.hold[1]      = 1'b1;
        st_next.held[2]      = analog_in[2];
        st_next.held[3]      = analog_in[3];
        st_next.span_held[1] = st_reg.sync_span[1];
      end
    end

    case (st_reg.state)
      ST_TRACK: begin
        // Start once both sets hold
        if (st_next.hold == 2'b11) begin
          st_next.state = ST_CONV;
          st_next.busy  = 1'b1;
          st_next.cnt   = '0;
        end
      end
      ST_CONV: begin
        st_next.cnt = st_reg.cnt + 8'h01;
        // Fixed internal timing
        if (st_reg.cnt == CONV_LAST) begin
          for (int i = 0; i < `CHANNELS; i++) begin
            st_next.result[i] = code_of(st_reg.held[i], st_reg.span_held[i/2]);
          end
          st_next.busy       = 1'b0;
          st_next.hold       = 2'b00;
          st_next.result_new = 1'b1;
          st_next.push_idx   = 2'b00;
          st_next.state      = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (push_ready) begin
          st_next.push_idx = st_reg.push_idx + 2'b01;
          if (st_reg.push_idx == 2'b11) begin
            st_next.state = ST_TRACK;
          end
        end
      end
      default: begin
        st_next.state = ST_TRACK;
      end
    endcase

    // Output flop, loads when empty or drained
    if (fifo_out_ready) begin
      st_next.out_valid = fifo_out_valid;
      st_next.out_word  = fifo_out_word;
    end
  end

  // Reset clears all state; the span is taken per set at each trigger
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Result stream
  // ****************************************
  assign push_valid     = (st_reg.state == ST_PUSH);
  assign push_word.chan = st_reg.push_idx;
  assign push_word.code = st_reg.result[st_reg.push_idx];
  // Head leaves the FIFO once the output flop frees
  assign fifo_out_ready = !st_reg.out_valid || stream_ready;

  word_fifo #(
    .WIDTH ($bits(fifo_word_t)),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_word)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign busy       = st_reg.busy;
  assign hold_state = st_reg.hold;
  assign result     = st_reg.result;
  assign result_new = st_reg.result_new;
  assign stream_valid = st_reg.out_valid;
  assign stream_data  = st_reg.out_word;

endmodule : conv_control

`default_nettype wire

// ===== bench/conv_control_props.sv
// Purpose: Port assertions of conv_control
// Assumes: Bound from the bench top
// Notes:   Busy lasts 200 cycles
`timescale 1ns/100ps
`default_nettype none
module conv_control_props
  import conv_pkg::*;
(
  input wire logic       sys_clk,      // Clock
  input wire logic       srst,         // Reset
  input wire logic       busy,         // Busy
  input wire logic [1:0] hold_state,   // Holds
  input wire code_set_t  result,       // Codes
  input wire logic       result_new,   // Update
  input wire logic       stream_valid, // Valid
  input wire logic       stream_ready, // Ready
  input wire fifo_word_t stream_data   // Word
);
  logic [8:0] cnt_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  always_ff @(posedge sys_clk) cnt_reg <= (srst || !busy) ? 9'h000 : cnt_reg + 9'h001;
  a_busy_len: assert property ($fell(busy) && !$past(srst) |-> cnt_reg == 9'h0C8)
    else $error("busy length");
  a_busy_held: assert property (busy |-> hold_state == 2'h3)
    else $error("hold");
  a_hold_free: assert property ($fell(busy) |-> hold_state == 2'h0)
    else $error("track");
  a_keep_res: assert property (!result_new && !$past(srst) |-> $stable(result))
    else $error("result");
  a_new_pulse: assert property (!$past(srst) |-> result_new == $fell(busy))
    else $error("new");
  a_word_next: assert property ($fell(busy) && !$past(srst) |=> ##1 stream_valid)
    else $error("word");
  a_word_keep: assert property (stream_valid && !stream_ready |=> stream_valid &&
    $stable(stream_data)) else $error("stall");
  a_hold_end: assert property ($past(hold_state) != 2'h0 && hold_state == 2'h0 &&
    !$past(srst) |-> $fell(busy)) else $error("hold end");
endmodule : conv_control_props
`default_nettype wire

// ===== bench/conv_host_model.sv
// Purpose: Host consumer of the result word stream
// Assumes: Stall changes on the falling edge
// Notes:   Counts only words in channel order
`timescale 1ns/100ps
`default_nettype none
module conv_host_model
  import conv_pkg::*;
(
  input  wire logic       sys_clk,      // Clock
  input  wire logic       stall,        // Hold off
  input  wire logic       stream_valid, // Valid
  output var  logic       stream_ready, // Ready
  input  wire fifo_word_t stream_data,  // Word
  output var  int         word_cnt      // Words in order
);
  int cnt_reg = 0;
  assign stream_ready = !stall;
  assign word_cnt = cnt_reg;
  always @(posedge sys_clk) begin
    if (stream_valid && stream_ready && stream_data.chan == cnt_reg[1:0]) begin
      cnt_reg <= cnt_reg + 1;
    end
  end
endmodule : conv_host_model
`default_nettype wire

// ===== bench/conv_control_test.sv
// Purpose: Self-checking bench of conv_control
// Assumes: Inputs move on the falling edge
// Notes:   Expected codes worked out here
`timescale 1ns/100ps
`default_nettype none
`include "conv_consts.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module conv_control_test
  import conv_pkg::*;
;
  localparam volt_set_t VA = {32'h00B71B00, 32'hFF676980, 32'h00000099, 32'h00000098};
  localparam volt_set_t VB = {32'hFFFFFFB3, 32'hFFFFFFB4, 32'h0000004D, 32'h0000004C};
  localparam volt_set_t VC = {32'hFFA47280, 32'h004C4B40, 32'h0, 32'h0};
  logic sys_clk = 1'b0, srst = 1'b1, trig_a = 1'b0, trig_b = 1'b0, span = 1'b0, stall = 1'b0;
  logic busy, result_new, stream_valid, stream_ready;
  logic [1:0] hold_state;
  code_set_t result;
  fifo_word_t stream_data;
  volt_set_t analog_in = '0;
  int word_cnt, errors = 0, samples_checked = 0;
  conv_control dut_u (.sys_clk(sys_clk), .srst(srst), .sample_trigger_first_set(trig_a),
    .sample_trigger_second_set(trig_b), .span_select(span), .analog_in(analog_in), .busy(busy),
    .hold_state(hold_state), .result(result), .result_new(result_new),
    .stream_valid(stream_valid), .stream_ready(stream_ready), .stream_data(stream_data));
  conv_host_model host_u (.sys_clk(sys_clk), .stall(stall), .stream_valid(stream_valid),
    .stream_ready(stream_ready), .stream_data(stream_data), .word_cnt(word_cnt));
  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end
  function automatic code_t exp_code(input volt_t v, input logic wide);
    longint fsr, q;
    fsr = wide ? `FSR_WIDE_UV : `FSR_NARROW_UV;
    q = ((longint'(v) + fsr / 2) * 2 * `CODE_STEPS + fsr) / (2 * fsr);
    return code_t'(q < 0 ? 0 : q >= `CODE_STEPS ? `CODE_STEPS - 1 : q) ^ `SIGN_FLIP;
  endfunction : exp_code
  task automatic words(input int n);
    for (int i = 0; i < 600 && word_cnt != n; i++) @(negedge sys_clk);
    `CHK(word_cnt, n)
  endtask : words
  task automatic run_conv(input logic split, input volt_set_t va, input volt_set_t vb);
    int i;
    code_set_t e;
    for (i = 0; i < 4; i++) e[i] = exp_code((i < 2) ? va[i] : vb[i], span);
    analog_in = va;
    {trig_a, trig_b} = {1'b1, !split};
    if (split) begin
      repeat (20) @(negedge sys_clk);
      `CHK({busy, hold_state}, 3'h1)
      {analog_in, trig_b} = {vb, 1'b1};
    end
    for (i = 0; i < 20 && !busy; i++) @(negedge sys_clk);
    `CHK(hold_state, 2'h3)
    {trig_a, trig_b} = 2'h0;
    for (i = 0; i < 300 && busy; i++) begin
      trig_a = (i >= 100);
      @(negedge sys_clk);
    end
    trig_a = 1'b0;
    `CHK({i[8:0], result_new, hold_state, result}, {9'h0C8, 3'h4, e})
    repeat (10) @(negedge sys_clk);
    `CHK({hold_state, result}, {2'h0, e})
  endtask : run_conv
  task automatic t_split_narrow();
    run_conv(1'b1, VB, VC);
    words(4);
  endtask : t_split_narrow
  task automatic t_fill_wide();
    span = 1'b1;
    repeat (8000) @(negedge sys_clk);
    stall = 1'b1;
    repeat (5) run_conv(1'b0, VA, VA);
    `CHK({stream_valid, word_cnt}, {1'b1, 32'h4})
    `CHK(stream_data, {2'h0, exp_code(VA[0], 1'b1)})
    stall = 1'b0;
    words(24);
    `CHK(stream_valid, 1'b0)
  endtask : t_fill_wide
  task automatic tally_and_finish();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4) @(negedge sys_clk);
    srst = 1'b0;
    t_split_narrow();
    t_fill_wide();
    tally_and_finish();
  end
endmodule : conv_control_test
bind conv_control conv_control_props chk_u (.sys_clk(sys_clk), .srst(srst), .busy(busy),
  .hold_state(hold_state), .result(result), .result_new(result_new),
  .stream_valid(stream_valid), .stream_ready(stream_ready), .stream_data(stream_data));
`default_nettype wire
